// file: ssim_pkg.sv
// constants, types and register map of the safe-stop input monitor
package ssim_pkg;

    localparam int CLK_KHZ       = 10000;
    localparam int EVAL_MS       = 10;
    localparam int EVAL_CYC_DEF  = EVAL_MS * CLK_KHZ;
    localparam int PULSE_US      = 500;
    localparam int PULSE_CYC_DEF = (PULSE_US * CLK_KHZ + 999) / 1000;
    localparam int SHUTOFF_MS    = 20;

    localparam logic [7:0] REL_MAX     = 8'hc8;
    localparam logic [7:0] FUNC_MAX    = 8'h40;
    localparam logic [7:0] FUNC_DISCR  = 8'h40;

    localparam logic [7:0] MODE_OFF    = 8'h00;
    localparam logic [7:0] MODE_SHUT   = 8'h01;
    localparam logic [7:0] MODE_MISM   = 8'h02;
    localparam logic [7:0] MODE_D05    = 8'h05;
    localparam logic [7:0] MODE_D06    = 8'h06;

    localparam logic [7:0] ADR_MODE    = 8'h00;
    localparam logic [7:0] ADR_RELTIME = 8'h04;
    localparam logic [7:0] ADR_OUTFUNC = 8'h08;
    localparam logic [7:0] ADR_STATUS  = 8'h0c;
    localparam logic [7:0] ADR_IRQSTAT = 8'h10;
    localparam logic [7:0] ADR_IRQMASK = 8'h14;
    localparam logic [7:0] ADR_CMD     = 8'h18;

    localparam int CANCEL_BIT  = 8;
    localparam int CMD_CLR_BIT = 0;
    localparam int CMD_KEY_BIT = 1;
    localparam int IRQ_W       = 6;

    localparam logic [7:0]       MODE_RST    = 8'h00;
    localparam logic [7:0]       REL_RST     = 8'h00;
    localparam logic [7:0]       FUNC_RST    = 8'h00;
    localparam logic [IRQ_W-1:0] IRQMASK_RST = 6'h00;

    localparam logic [2:0] IND_NONE = 3'h0;
    localparam logic [2:0] IND_STOP = 3'h1;
    localparam logic [2:0] IND_F01  = 3'h2;
    localparam logic [2:0] IND_F02  = 3'h3;
    localparam logic [2:0] IND_F10  = 3'h4;
    localparam logic [2:0] IND_F20  = 3'h5;

    typedef enum logic [4:0] {
        CLS_CLOSED = 5'h01,
        CLS_FIRST  = 5'h02,
        CLS_SECOND = 5'h04,
        CLS_OPEN   = 5'h08,
        CLS_FAIL   = 5'h10
    } ssim_cls_t;

    typedef enum logic [3:0] {
        TRIP_NONE = 4'h1,
        TRIP_SHUT = 4'h2,
        TRIP_MISM = 4'h4,
        TRIP_INTF = 4'h8
    } ssim_trip_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } ssim_wbreq_t;

endpackage : ssim_pkg

// file: ssim_top.sv
// safe-stop input monitor: classification, trips, indications, discrepancy output
//
// Contract
// - classify contacts and fault into five states
// - trip and indication per input mode select
// - class changes raise events driving transitions
// - release timeout event only in mode 05
// - discrepancy off during trip or delay
// - discrepancy follows inputs only in 05/06
// - other modes: discrepancy on unless tripped
// - delay keeps discrepancy off despite cancel
// - discrepancy re-evaluated every 10 ms
// - function code 64 routes discrepancy to outputs
// - monitoring active right after reset
// - release time programmable 0.00 to 2.00 s
// - after timeout recover only via both open
// - motor shut off within 20 ms
//
// Chosen here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
module ssim_top import ssim_pkg::*; #(
    parameter logic [16:0] EVAL_CYC  = 17'(EVAL_CYC_DEF),
    parameter logic [15:0] PULSE_CYC = 16'(PULSE_CYC_DEF)
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        firstStopInput,
    input  wire logic        secondStopInput,
    input  wire logic        internalFault,
    input  wire ssim_wbreq_t wbReq,
    output logic             wbAck,
    output logic [31:0]      wbDatO,
    output logic             irq,
    output logic             motorEnable,
    output logic             discrepancyOutput,
    output logic             outTerminalA,
    output logic             outTerminalB,
    output logic             alarmRelay,
    output logic [2:0]       indicationCode,
    output ssim_trip_t       tripCode
);

    logic [2:0]       syncA_q;
    logic [2:0]       syncB_q;
    logic [1:0]       flt;
    ssim_cls_t        cls;
    ssim_cls_t        clsPrev_q;
    ssim_trip_t       trip_q;
    ssim_trip_t       tripSet;
    logic [7:0]       mode_q;
    logic             cancelSel_q;
    logic [7:0]       relTime_q;
    logic [7:0]       funcA_q;
    logic [7:0]       funcB_q;
    logic [7:0]       funcAl_q;
    logic [IRQ_W-1:0] irqStat_q;
    logic [IRQ_W-1:0] irqMask_q;
    logic [IRQ_W-1:0] irqEv;
    logic             ack_q;
    logic [31:0]      datO_q;
    logic [16:0]      tickCnt_q;
    logic [7:0]       relCnt_q;
    logic             fromOpen_q;
    logic             delay_q;
    logic [2:0]       delCode_q;
    logic             lockout_q;
    logic             hide_q;
    logic [2:0]       indPrev_q;
    logic [2:0]       indOut_q;
    logic             discr_q;
    logic             motor_q;
    logic             outA_q;
    logic             outB_q;
    logic             outAl_q;
    logic             irq_q;

    // pins pass two flops; stage one feeds only stage two
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            syncA_q <= 3'h0;
            syncB_q <= 3'h0;
        end else begin
            syncA_q <= {internalFault, secondStopInput, firstStopInput};
            syncB_q <= syncA_q;
        end
    end

    // off-pulses up to the test width are ignored; adds PULSE_CYC + 1 cycles (500.1 us), well inside the shut-off budget
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_filt
            logic        f_q;
            logic [15:0] c_q;
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    f_q <= 1'b0;
                    c_q <= 16'h0000;
                end else if (syncB_q[g] == f_q) begin
                    c_q <= 16'h0000;
                end else if (c_q == PULSE_CYC) begin
                    f_q <= syncB_q[g];
                    c_q <= 16'h0000;
                end else begin
                    c_q <= c_q + 16'h0001;
                end
            end
            assign flt[g] = f_q;
        end
    endgenerate

    // contact closed reads as 1
    assign cls = syncB_q[2]      ? CLS_FAIL :
                 (flt == 2'b11)  ? CLS_CLOSED :
                 (flt == 2'b10)  ? CLS_FIRST :
                 (flt == 2'b01)  ? CLS_SECOND : CLS_OPEN;

    wire mismatch  = (cls == CLS_FIRST) || (cls == CLS_SECOND);
    wire modeDelay = (mode_q == MODE_D05) || (mode_q == MODE_D06);
    wire modeStop  = (mode_q >= MODE_MISM) && (mode_q <= MODE_D06);
    wire tick      = (tickCnt_q == EVAL_CYC - 17'h00001);
    wire tripped   = (trip_q != TRIP_NONE);

    // bus decode
    wire       wbReqOn = wbReq.cyc && wbReq.stb && !ack_q;
    // writes land on the edge at which the master sees ack, while the request still stands
    wire       wbWr    = wbReq.cyc && wbReq.stb && wbReq.we && ack_q;
    wire       wrMode  = wbWr && (wbReq.adr == ADR_MODE);
    wire       wrRel   = wbWr && (wbReq.adr == ADR_RELTIME) && wbReq.sel[0];
    wire       wrFunc  = wbWr && (wbReq.adr == ADR_OUTFUNC);
    wire       wrStat  = wbWr && (wbReq.adr == ADR_IRQSTAT) && wbReq.sel[0];
    wire       wrMask  = wbWr && (wbReq.adr == ADR_IRQMASK) && wbReq.sel[0];
    wire       wrCmd   = wbWr && (wbReq.adr == ADR_CMD) && wbReq.sel[0];
    wire       tripClr = wrCmd && wbReq.dat[CMD_CLR_BIT];
    wire       keyHit  = wrCmd && wbReq.dat[CMD_KEY_BIT];
    wire [7:0] wB0     = wbReq.dat[7:0];
    wire [7:0] wB1     = wbReq.dat[15:8];
    wire [7:0] wB2     = wbReq.dat[23:16];

    // release timing in mode 05 while coming back from stop
    wire relWatch = (mode_q == MODE_D05) && fromOpen_q && mismatch && !lockout_q;
    wire timeout  = relWatch && tick && (relCnt_q >= relTime_q);

    // delay codes: which contact lags, and in which direction
    wire delayNow = modeDelay && mismatch && (!fromOpen_q || (mode_q == MODE_D06) || timeout);
    wire [2:0] delSel = (cls == CLS_FIRST) ? (fromOpen_q ? IND_F01 : IND_F20) :
                                             (fromOpen_q ? IND_F02 : IND_F10);
    wire delayClr = (cls == CLS_OPEN) || ((cls == CLS_CLOSED) && !lockout_q);

    assign tripSet = (cls == CLS_FAIL) ? TRIP_INTF :
                     ((mode_q == MODE_SHUT) && (cls != CLS_CLOSED)) ? TRIP_SHUT :
                     ((mode_q == MODE_MISM) && mismatch) ? TRIP_MISM : TRIP_NONE;

    wire [2:0] indNow = delay_q ? delCode_q :
                        (modeStop && (cls == CLS_OPEN)) ? IND_STOP : IND_NONE;

    wire discrNext = tripped ? 1'b0 :
                     modeDelay ? (!delay_q && !mismatch && (cls != CLS_FAIL)) : 1'b1;

    wire clsChg = (cls != clsPrev_q);
    assign irqEv = {(trip_q == TRIP_NONE) && (tripSet != TRIP_NONE),
                    timeout,
                    clsChg && (cls == CLS_OPEN),
                    clsChg && (cls == CLS_FAIL),
                    clsChg && mismatch && !((clsPrev_q == CLS_FIRST) || (clsPrev_q == CLS_SECOND)),
                    clsChg && (cls == CLS_CLOSED)};

    wire [31:0] rdStatus = {17'h00000, motor_q, lockout_q, discr_q, indOut_q, trip_q, cls};
    wire [31:0] rdData   = (wbReq.adr == ADR_MODE)    ? {23'h000000, cancelSel_q, mode_q} :
                           (wbReq.adr == ADR_RELTIME) ? {24'h000000, relTime_q} :
                           (wbReq.adr == ADR_OUTFUNC) ? {8'h00, funcAl_q, funcB_q, funcA_q} :
                           (wbReq.adr == ADR_STATUS)  ? rdStatus :
                           (wbReq.adr == ADR_IRQSTAT) ? {26'h0000000, irqStat_q} :
                           (wbReq.adr == ADR_IRQMASK) ? {26'h0000000, irqMask_q} : 32'h00000000;

    // wishbone slave: one wait state, unmapped reads zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ack_q  <= 1'b0;
            datO_q <= 32'h00000000;
        end else begin
            ack_q  <= wbReqOn;
            datO_q <= wbReqOn ? rdData : 32'h00000000;
        end
    end

    // configuration; out-of-range values are refused and the old value kept
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode_q      <= MODE_RST;
            cancelSel_q <= 1'b0;
            relTime_q   <= REL_RST;
            funcA_q     <= FUNC_RST;
            funcB_q     <= FUNC_RST;
            funcAl_q    <= FUNC_RST;
            irqMask_q   <= IRQMASK_RST;
        end else begin
            if (wrMode && wbReq.sel[0] && (wB0 <= MODE_D06))
                mode_q <= wB0;
            if (wrMode && wbReq.sel[1])
                cancelSel_q <= wbReq.dat[CANCEL_BIT];
            if (wrRel && (wB0 <= REL_MAX))
                relTime_q <= wB0;
            if (wrFunc && wbReq.sel[0] && (wB0 <= FUNC_MAX))
                funcA_q <= wB0;
            if (wrFunc && wbReq.sel[1] && (wB1 <= FUNC_MAX))
                funcB_q <= wB1;
            if (wrFunc && wbReq.sel[2] && (wB2 <= FUNC_MAX))
                funcAl_q <= wB2;
            if (wrMask)
                irqMask_q <= wB0[IRQ_W-1:0];
        end
    end

    // sticky events; a new event beats a write-one-to-clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irqStat_q <= '0;
            irq_q     <= 1'b0;
        end else begin
            irqStat_q <= (irqStat_q & ~(wrStat ? wB0[IRQ_W-1:0] : 6'h00)) | irqEv;
            irq_q     <= |(irqStat_q & irqMask_q);
        end
    end

    // trips; the internal-failure trip is left only through rst (power-up)
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            trip_q <= TRIP_NONE;
        end else if (trip_q != TRIP_INTF) begin
            if (tripSet == TRIP_INTF)
                trip_q <= TRIP_INTF;
            else if ((trip_q == TRIP_NONE) || tripClr)
                trip_q <= tripSet;
        end
    end

    // sequence state for the delay modes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clsPrev_q  <= CLS_OPEN;
            fromOpen_q <= 1'b1;
            relCnt_q   <= 8'h00;
            lockout_q  <= 1'b0;
            delay_q    <= 1'b0;
            delCode_q  <= IND_NONE;
            tickCnt_q  <= 17'h00000;
        end else begin
            clsPrev_q <= cls;
            tickCnt_q <= tick ? 17'h00000 : tickCnt_q + 17'h00001;
            if (cls == CLS_OPEN)
                fromOpen_q <= 1'b1;
            else if (cls == CLS_CLOSED)
                fromOpen_q <= 1'b0;
            if (!relWatch)
                relCnt_q <= 8'h00;
            else if (tick && (relCnt_q != REL_MAX))
                relCnt_q <= relCnt_q + 8'h01;
            if (timeout)
                lockout_q <= 1'b1;
            else if (cls == CLS_OPEN)
                lockout_q <= 1'b0;
            if (delayNow && !delay_q) begin
                delay_q   <= 1'b1;
                delCode_q <= delSel;
            end else if (delayClr && !delayNow) begin
                delay_q   <= 1'b0;
                delCode_q <= IND_NONE;
            end
        end
    end

    // panel cancel hides the indication only; a changed indication shows again
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hide_q    <= 1'b0;
            indPrev_q <= IND_NONE;
            indOut_q  <= IND_NONE;
        end else begin
            indPrev_q <= indNow;
            if (indNow != indPrev_q)
                hide_q <= 1'b0;
            else if (keyHit && cancelSel_q && (indNow != IND_NONE))
                hide_q <= 1'b1;
            indOut_q <= (hide_q && (indNow == indPrev_q)) ? IND_NONE : indNow;
        end
    end

    // outputs; motor gating runs from reset on, no enable needed
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            discr_q <= 1'b0;
            motor_q <= 1'b0;
            outA_q  <= 1'b0;
            outB_q  <= 1'b0;
            outAl_q <= 1'b0;
        end else begin
            if (tick)
                discr_q <= discrNext;
            motor_q <= (cls == CLS_CLOSED) && !tripped && !lockout_q;
            outA_q  <= (funcA_q == FUNC_DISCR) && discr_q;
            outB_q  <= (funcB_q == FUNC_DISCR) && discr_q;
            outAl_q <= (funcAl_q == FUNC_DISCR) && discr_q;
        end
    end

    assign wbAck             = ack_q;
    assign wbDatO            = datO_q;
    assign irq               = irq_q;
    assign motorEnable       = motor_q;
    assign discrepancyOutput = discr_q;
    assign outTerminalA      = outA_q;
    assign outTerminalB      = outB_q;
    assign alarmRelay        = outAl_q;
    assign indicationCode    = indOut_q;
    assign tripCode          = trip_q;

endmodule : ssim_top

// file: ssim_relay_model.sv
// external safety relay driving both stop contacts, with optional test off-pulses
`timescale 1ns/10ps
module ssim_relay_model #(
    parameter int PULSE_LEN = 4
) (
    input  wire logic       sys_clk,
    input  wire logic [1:0] closeReq,
    input  wire logic       pulseReq,
    output logic            firstContact,
    output logic            secondContact
);
    // contacts are unknown until the first edge; the bench holds reset over it
    int pulseCnt = 0;
    // off-pulse never longer than PULSE_LEN cycles, both lines together
    always @(posedge sys_clk) begin
        if (pulseReq && pulseCnt == 0) begin
            pulseCnt <= PULSE_LEN;
        end else if (pulseCnt > 0) begin
            pulseCnt <= pulseCnt - 1;
        end
        firstContact  <= closeReq[0] && pulseCnt == 0;
        secondContact <= closeReq[1] && pulseCnt == 0;
    end
endmodule : ssim_relay_model

// file: ssim_top_checker.sv
// port assertions of the safe-stop input monitor
`timescale 1ns/10ps
module ssim_top_checker import ssim_pkg::*; #(
    parameter logic [16:0] EVAL_CYC  = 17'(EVAL_CYC_DEF),
    parameter logic [15:0] PULSE_CYC = 16'(PULSE_CYC_DEF)
) (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        firstStopInput,
    input wire logic        secondStopInput,
    input wire logic        internalFault,
    input wire ssim_wbreq_t wbReq,
    input wire logic        wbAck,
    input wire logic [31:0] wbDatO,
    input wire logic        motorEnable,
    input wire logic        discrepancyOutput,
    input wire logic        outTerminalA,
    input wire logic        outTerminalB,
    input wire logic        alarmRelay,
    input wire ssim_trip_t  tripCode
);
    logic [17:0] openCnt_q;
    logic [17:0] faultCnt_q;
    logic [17:0] tripCnt_q;
    // run-length counters, 18 bits outlast any simulation here
    always_ff @(posedge sys_clk) begin
        openCnt_q  <= (rst || firstStopInput || secondStopInput) ? '0 : openCnt_q + 18'h1;
        faultCnt_q <= (rst || !internalFault) ? '0 : faultCnt_q + 18'h1;
        tripCnt_q  <= (rst || tripCode == TRIP_NONE) ? '0 : tripCnt_q + 18'h1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    ack_single_a: assert property (wbAck |=> !wbAck) else $error("ack longer than one cycle");
    ack_cause_a: assert property (wbAck |-> $past(wbReq.cyc) && $past(wbReq.stb)) else $error("ack without request");
    data_idle_a: assert property (!wbAck |-> wbDatO == 32'h0) else $error("read data without ack");
    trip_onehot_a: assert property ($onehot(tripCode)) else $error("trip code not one-hot");
    fault_trip_a: assert property (faultCnt_q > 18'(PULSE_CYC) + 18'h8 |-> tripCode == TRIP_INTF)
        else $error("fault without internal trip");
    fault_latch_a: assert property (tripCode == TRIP_INTF |=> tripCode == TRIP_INTF)
        else $error("internal trip released");
    trip_disc_a: assert property (tripCnt_q > 18'(EVAL_CYC) + 18'h2 |-> !discrepancyOutput)
        else $error("discrepancy on in trip");
    disc_hold_a: assert property ($changed(discrepancyOutput) |=> $stable(discrepancyOutput) [*8])
        else $error("discrepancy changed between ticks");
    out_route_a: assert property ((outTerminalA || outTerminalB || alarmRelay) |-> $past(discrepancyOutput))
        else $error("terminal high without discrepancy");
    motor_stop_a: assert property (openCnt_q > 18'(PULSE_CYC) + 18'h6 |-> !motorEnable)
        else $error("motor enabled with both contacts open");
endmodule : ssim_top_checker
bind ssim_top ssim_top_checker #(.EVAL_CYC(EVAL_CYC), .PULSE_CYC(PULSE_CYC)) i_chk (.sys_clk, .rst,
    .firstStopInput, .secondStopInput, .internalFault, .wbReq, .wbAck, .wbDatO, .motorEnable,
    .discrepancyOutput, .outTerminalA, .outTerminalB, .alarmRelay, .tripCode);

// file: ssim_tb.sv
// self-checking bench of the safe-stop input monitor
`timescale 1ns/10ps
module tb import ssim_pkg::*;;
    localparam int EC = 20;
    localparam int PC = 4;
    // exp: motor, lockout, discrepancy, indication, trip
    typedef struct packed {logic [7:0] mode; logic [1:0] cls; logic flt; logic [9:0] exp;} ssim_row_t;
    ssim_row_t   rows [13] = '{'{8'h00, 2'b11, 1'b0, 10'h281}, '{8'h00, 2'b00, 1'b0, 10'h081},
        '{8'h01, 2'b01, 1'b0, 10'h002}, '{8'h01, 2'b00, 1'b0, 10'h002}, '{8'h02, 2'b10, 1'b0, 10'h004},
        '{8'h02, 2'b00, 1'b0, 10'h091}, '{8'h03, 2'b00, 1'b0, 10'h091}, '{8'h04, 2'b01, 1'b0, 10'h081},
        '{8'h06, 2'b01, 1'b0, 10'h031}, '{8'h06, 2'b10, 1'b0, 10'h021}, '{8'h05, 2'b00, 1'b0, 10'h091},
        '{8'h05, 2'b01, 1'b0, 10'h131}, '{8'h00, 2'b11, 1'b1, 10'h008}};
    logic        sys_clk, rst, internalFault, pulseReq, wbAck, irq, motorEnable;
    logic        firstStopInput, secondStopInput, discrepancyOutput, outTerminalA, outTerminalB, alarmRelay;
    logic [1:0]  closeReq;
    logic [2:0]  indicationCode;
    logic [31:0] wbDatO, rd;
    ssim_trip_t  tripCode;
    ssim_wbreq_t wbReq;
    int          n_mismatch = 0;
    int          n_checks = 0;
    ssim_top #(.EVAL_CYC(17'(EC)), .PULSE_CYC(16'(PC))) i_dut (.sys_clk, .rst, .firstStopInput, .secondStopInput,
        .internalFault, .wbReq, .wbAck, .wbDatO, .irq, .motorEnable, .discrepancyOutput, .outTerminalA,
        .outTerminalB, .alarmRelay, .indicationCode, .tripCode);
    ssim_relay_model #(.PULSE_LEN(PC)) i_relay (.sys_clk, .closeReq, .pulseReq,
        .firstContact(firstStopInput), .secondContact(secondStopInput));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wait_cyc
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, seen);
            n_mismatch++;
        end
    endtask : check
    // holds the request until ack is sampled, then idles one cycle
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int t;
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
        t = 0;
        do begin
            @(posedge sys_clk);
            t++;
        end while (wbAck !== 1'b1 && t < 50);
        rd = wbDatO;
        wbReq <= '0;
        if (t >= 50) n_mismatch++;
        @(posedge sys_clk);
    endtask : wb
    task automatic do_rst();
        rst <= 1'b1;
        wait_cyc(2);
        rst <= 1'b0;
        wait_cyc(1);
    endtask : do_rst
    function automatic logic [4:0] cls_of(input logic [1:0] c, input logic f);
        return f ? CLS_FAIL : c == 2'b11 ? CLS_CLOSED : c == 2'b00 ? CLS_OPEN : c[1] ? CLS_FIRST : CLS_SECOND;
    endfunction : cls_of
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    initial begin
        #1_000_000;
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        rst <= 1'b1;
        internalFault <= 1'b0;
        pulseReq <= 1'b0;
        closeReq <= 2'b00;
        wbReq <= '0;
        wait_cyc(20);
        rst <= 1'b0;
        wait_cyc(1);
        check("trip at reset", tripCode, TRIP_NONE);
        wb(0, 8'h1c, 32'h0);
        check("unmapped", rd, 32'h0);
        wb(0, ADR_IRQMASK, 32'h0);
        check("mask reset", rd, 32'(IRQMASK_RST));
        foreach (rows[i]) begin
            closeReq <= rows[i].cls;
            internalFault <= rows[i].flt;
            do_rst();
            wb(1, ADR_MODE, {24'h0, rows[i].mode});
            wb(1, ADR_OUTFUNC, 32'h404040);
            wait_cyc(60);
            wb(0, ADR_STATUS, 32'h0);
            check("status", rd[14:0], {rows[i].exp, cls_of(rows[i].cls, rows[i].flt)});
            check("terminals", {outTerminalA, outTerminalB, alarmRelay}, {3{rows[i].exp[7]}});
            wb(0, ADR_IRQSTAT, 32'h0);
            check("timeout event", rd[4], rows[i].exp[8]);
        end
        internalFault <= 1'b0;
        wb(1, ADR_CMD, 32'h1);
        wait_cyc(20);
        check("fault trip kept", tripCode, TRIP_INTF);
        closeReq <= 2'b11;
        do_rst();
        wait_cyc(30);
        // off-pulse as long as the filter width must not drop the motor
        pulseReq <= 1'b1;
        wait_cyc(1);
        pulseReq <= 1'b0;
        repeat (15) begin
            @(posedge sys_clk);
            check("motor during pulse", motorEnable, 1'b1);
        end
        wb(1, ADR_MODE, 32'h106);
        closeReq <= 2'b10;
        wait_cyc(50);
        check("stop delay", indicationCode, IND_F20);
        wb(1, ADR_CMD, 32'h2);
        wait_cyc(30);
        check("cancelled", indicationCode, IND_NONE);
        check("discrepancy after cancel", discrepancyOutput, 1'b0);
        closeReq <= 2'b01;
        do_rst();
        wb(1, ADR_MODE, 32'h5);
        wb(1, ADR_RELTIME, 32'h2);
        wb(1, ADR_IRQMASK, 32'h10);
        wait_cyc(120);
        check("irq timeout", irq, 1'b1);
        wb(1, ADR_IRQMASK, 32'h0);
        wait_cyc(3);
        check("irq masked", irq, 1'b0);
        closeReq <= 2'b11;
        wait_cyc(40);
        check("locked out", motorEnable, 1'b0);
        wb(1, ADR_IRQSTAT, 32'h10);
        wb(0, ADR_IRQSTAT, 32'h0);
        check("event cleared", rd[4], 1'b0);
        closeReq <= 2'b00;
        wait_cyc(40);
        closeReq <= 2'b11;
        wait_cyc(40);
        check("restored", motorEnable, 1'b1);
        report_and_stop();
    end
endmodule : tb
